// ### core/dgc_pkg.sv
// Overview of operation
// [RULE1] each register has clear, set, invert aliases at plus 0x4, 0x8, 0xC; the interrupt status register ignores alias writes
// [RULE2] alias writes change only bits whose written data bit is one
// [RULE3] unimplemented bits ignore writes and read as zero
// [RULE4] global enable bit 15 turns the whole controller on or off; resets zero
// [RULE5] suspend bit 12 holds off all transfers for processor bus access
// [RULE6] module-active bit 11 reads one whenever the controller is active
// [RULE7] module-active reads zero only when disabled and no transfer in progress
// [RULE8] extended control resets to 0x00FFFFF8; all other channel registers zero
// [RULE9] software avoids register access right after clearing enable at 1:1 clock
package dgc_pkg;
   // ==========================================================
   // register offsets
   localparam logic [15:0] OFS_GLOBAL   = 16'h3000;
   localparam logic [15:0] OFS_IRQ_STAT = 16'h3400;
   localparam logic [15:0] OFS_IRQ_MASK = 16'h3410;
   localparam logic [15:0] OFS_C2_DAT   = 16'h3290;
   localparam logic [15:0] OFS_C2_CPTR  = 16'h3280;
   localparam logic [15:0] OFS_C3_CON   = 16'h32A0;
   localparam logic [15:0] OFS_C3_ECON  = 16'h32B0;
   localparam logic [15:0] OFS_C3_INT   = 16'h32C0;
   localparam logic [15:0] OFS_C3_SSA   = 16'h32D0;
   localparam logic [15:0] OFS_C3_DSA   = 16'h32E0;
   localparam logic [15:0] OFS_C3_SSIZ  = 16'h32F0;
   localparam logic [15:0] OFS_C3_DSIZ  = 16'h3300;
   localparam logic [15:0] OFS_C3_SPTR  = 16'h3310;
   localparam logic [15:0] OFS_C3_DPTR  = 16'h3320;
   localparam logic [15:0] OFS_C3_CSIZ  = 16'h3330;
   localparam logic [15:0] OFS_C3_CPTR  = 16'h3340;
   localparam logic [15:0] OFS_C3_DAT   = 16'h3350;
   // ==========================================================
   // alias sub-offsets
   localparam logic [1:0] ALIAS_NONE = 2'h0;
   localparam logic [1:0] ALIAS_CLR  = 2'h1;
   localparam logic [1:0] ALIAS_SET  = 2'h2;
   localparam logic [1:0] ALIAS_INV  = 2'h3;
   // ==========================================================
   // field positions and writable masks
   localparam int BIT_ON      = 15;
   localparam int BIT_SUSPEND = 12;
   localparam int BIT_ACTIVE  = 11;
   localparam int BIT_CHEN    = 7;
   localparam int BIT_CHBUSY  = 15;
   localparam logic [31:0] MSK_GLOBAL = 32'h0000_9000;
   localparam logic [31:0] MSK_CON    = 32'h0000_81F7;
   localparam logic [31:0] MSK_ECON   = 32'h00FF_FFF8;
   localparam logic [31:0] MSK_INT    = 32'h00FF_00FF;
   localparam logic [31:0] MSK_HALF   = 32'h0000_FFFF;
   localparam logic [31:0] MSK_BYTE   = 32'h0000_00FF;
   localparam logic [31:0] MSK_IRQ    = 32'h0000_0003;
   // ==========================================================
   // reset values
   localparam logic [31:0] RST_ECON = 32'h00FF_FFF8;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // ==========================================================
   // bus carrier
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } dgc_bus_t;
endpackage : dgc_pkg

// ### core/dgc_regs.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module dgc_regs
   import dgc_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire dgc_bus_t    bus_i,
   input  wire logic        xfer_busy_i,
   input  wire logic [15:0] c3_sptr_i,
   input  wire logic [15:0] c3_dptr_i,
   input  wire logic [15:0] c3_cptr_i,
   input  wire logic [15:0] c2_cptr_i,
   output logic      [31:0] rdata_o,
   output logic             dma_on_o,
   output logic             xfer_allow_o,
   output logic             module_active_o,
   output logic             irq_o
);
   // ==========================================================
   // check clock and reset
   default clocking dgc_cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   // ==========================================================
   // alias write helper
   function automatic logic [31:0] upd(input logic [31:0] cur,
                                       input logic [31:0] wd,
                                       input logic [1:0]  kind,
                                       input logic [31:0] msk);
      logic [31:0] n;
      case (kind)
         ALIAS_NONE: n = wd;
         ALIAS_CLR:  n = cur & ~wd; // RULE2
         ALIAS_SET:  n = cur | wd; // RULE2
         ALIAS_INV:  n = cur ^ wd; // RULE2
         default:    n = cur;
      endcase
      return n & msk; // RULE3
   endfunction : upd

   // ==========================================================
   // decode
   logic [15:0] base;
   logic [1:0]  kind;
   logic [31:0] wd;
   assign base = {bus_i.addr[15:4], 4'h0};
   assign kind = bus_i.addr[3:2]; // RULE1
   assign wd   = bus_i.wdata;

   function automatic logic hit(input logic [15:0] b,
                                input logic [15:0] ofs);
      return b == ofs;
   endfunction : hit

   // ==========================================================
   // registers
   logic [31:0] glb;
   logic [31:0] c3_con;
   logic [31:0] c3_econ;
   logic [31:0] c3_int;
   logic [31:0] c3_ssa;
   logic [31:0] c3_dsa;
   logic [31:0] c3_ssiz;
   logic [31:0] c3_dsiz;
   logic [31:0] c3_csiz;
   logic [31:0] c3_dat;
   logic [31:0] c2_dat;
   logic [31:0] irq_stat;
   logic [31:0] irq_mask;
   logic        busy_q;
   logic        on_q;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         glb <= RST_ZERO; // RULE4
      end else if (bus_i.wr && hit(base, OFS_GLOBAL)) begin
         glb <= upd(glb, wd, kind, MSK_GLOBAL); // RULE1 RULE4 RULE5
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         c3_con  <= RST_ZERO; // RULE8
         c3_econ <= RST_ECON; // RULE8
         c3_int  <= RST_ZERO;
         c3_ssa  <= RST_ZERO;
         c3_dsa  <= RST_ZERO;
         c3_ssiz <= RST_ZERO;
         c3_dsiz <= RST_ZERO;
         c3_csiz <= RST_ZERO;
         c3_dat  <= RST_ZERO;
         c2_dat  <= RST_ZERO;
      end else if (bus_i.wr) begin
         if (hit(base, OFS_C3_CON))
            c3_con <= upd(c3_con, wd, kind, MSK_CON);
         if (hit(base, OFS_C3_ECON))
            c3_econ <= upd(c3_econ, wd, kind, MSK_ECON);
         if (hit(base, OFS_C3_INT))
            c3_int <= upd(c3_int, wd, kind, MSK_INT);
         if (hit(base, OFS_C3_SSA))
            c3_ssa <= upd(c3_ssa, wd, kind, '1);
         if (hit(base, OFS_C3_DSA))
            c3_dsa <= upd(c3_dsa, wd, kind, '1);
         if (hit(base, OFS_C3_SSIZ))
            c3_ssiz <= upd(c3_ssiz, wd, kind, MSK_HALF);
         if (hit(base, OFS_C3_DSIZ))
            c3_dsiz <= upd(c3_dsiz, wd, kind, MSK_HALF);
         if (hit(base, OFS_C3_CSIZ))
            c3_csiz <= upd(c3_csiz, wd, kind, MSK_HALF);
         if (hit(base, OFS_C3_DAT))
            c3_dat <= upd(c3_dat, wd, kind, MSK_BYTE);
         if (hit(base, OFS_C2_DAT))
            c2_dat <= upd(c2_dat, wd, kind, MSK_BYTE);
      end
   end

   // ==========================================================
   // busy and enable status
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_q       <= 1'b0;
         on_q         <= 1'b0;
         xfer_allow_o <= 1'b0;
      end else begin
         busy_q       <= glb[BIT_ON] | xfer_busy_i; // RULE6 RULE7
         on_q         <= glb[BIT_ON];
         xfer_allow_o <= glb[BIT_ON] & ~glb[BIT_SUSPEND]; // RULE5
      end
   end

   assign dma_on_o        = on_q;
   assign module_active_o = busy_q;

   // ==========================================================
   // interrupt: bit0 enable fell, bit1 module-active fell (enable off and no transfer)
   logic busy_d;
   logic [31:0] ev;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i)
         busy_d <= 1'b0;
      else
         busy_d <= busy_q;
   end
   assign ev = {30'h0, busy_d & ~busy_q, on_q & ~glb[BIT_ON]};

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_stat <= RST_ZERO;
         irq_mask <= RST_ZERO;
      end else begin
         if (bus_i.wr && hit(base, OFS_IRQ_STAT) && kind == ALIAS_NONE)
            irq_stat <= ((irq_stat & ~wd) | ev) & MSK_IRQ;
         else
            irq_stat <= (irq_stat | ev) & MSK_IRQ;
         if (bus_i.wr && hit(base, OFS_IRQ_MASK))
            irq_mask <= upd(irq_mask, wd, kind, MSK_IRQ);
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |(((irq_stat | ev) & irq_mask & MSK_IRQ));
   end

   // ==========================================================
   // read port
   logic [31:0] glb_rd;
   logic [31:0] con_rd;
   logic [31:0] next_rdata;
   assign glb_rd = {glb[31:12], busy_q, glb[10:0]}; // RULE6
   assign con_rd = c3_con | ({31'h0, xfer_busy_i} << BIT_CHBUSY);

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (bus_i.rd && kind == ALIAS_NONE) begin
         case (base)
            OFS_GLOBAL:   next_rdata = glb_rd;
            OFS_C3_CON:   next_rdata = con_rd;
            OFS_C3_ECON:  next_rdata = c3_econ;
            OFS_C3_INT:   next_rdata = c3_int;
            OFS_C3_SSA:   next_rdata = c3_ssa;
            OFS_C3_DSA:   next_rdata = c3_dsa;
            OFS_C3_SSIZ:  next_rdata = c3_ssiz;
            OFS_C3_DSIZ:  next_rdata = c3_dsiz;
            OFS_C3_SPTR:  next_rdata = {16'h0, c3_sptr_i};
            OFS_C3_DPTR:  next_rdata = {16'h0, c3_dptr_i};
            OFS_C3_CSIZ:  next_rdata = c3_csiz;
            OFS_C3_CPTR:  next_rdata = {16'h0, c3_cptr_i};
            OFS_C3_DAT:   next_rdata = c3_dat;
            OFS_C2_CPTR:  next_rdata = {16'h0, c2_cptr_i};
            OFS_C2_DAT:   next_rdata = c2_dat;
            OFS_IRQ_STAT: next_rdata = irq_stat;
            OFS_IRQ_MASK: next_rdata = irq_mask;
            default:      next_rdata = 32'h0000_0000; // RULE3
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i)
         rdata_o <= 32'h0000_0000;
      else
         rdata_o <= next_rdata;
   end

   // ==========================================================
   // checks
   chk_alias_set_bits: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      bus_i.wr && hit(base, OFS_C3_SSA) && kind == ALIAS_SET
      |=> (c3_ssa & $past(wd)) == $past(wd)) // RULE1
      else $error("set alias missed bits");
   chk_alias_keep: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      bus_i.wr && hit(base, OFS_C3_DSA) && kind == ALIAS_CLR
      |=> c3_dsa == ($past(c3_dsa) & ~$past(wd))) // RULE2
      else $error("clear alias wrong");
   chk_unimpl_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      (glb & ~MSK_GLOBAL) == 32'h0 && (c3_econ & ~MSK_ECON) == 32'h0) // RULE3
      else $error("unimplemented bit set");
   chk_on_write: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      bus_i.wr && base == OFS_GLOBAL && kind == ALIAS_NONE
      |=> glb[BIT_ON] == $past(wd[BIT_ON])) // RULE4
      else $error("enable write lost");
   chk_suspend_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      glb[BIT_SUSPEND] |=> !xfer_allow_o) // RULE5
      else $error("transfer allowed while suspended");
   chk_active_on: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      glb[BIT_ON] |=> module_active_o) // RULE6
      else $error("active low while enabled");
   chk_active_idle: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      !$past(glb[BIT_ON]) && !$past(xfer_busy_i) |-> !module_active_o) // RULE7
      else $error("active high while idle");
   chk_econ_reset: assert property (@(posedge mclk_i)
      $rose(nrst_i) |-> c3_econ == RST_ECON) // RULE8
      else $error("extended control reset wrong");

   // ==========================================================
   // enable sequences
   sequence s_on_clr_wr;
      bus_i.wr && hit(base, OFS_GLOBAL) && kind == ALIAS_CLR
         && wd[BIT_ON];
   endsequence
   sequence s_on_set_wr;
      bus_i.wr && hit(base, OFS_GLOBAL) && kind == ALIAS_SET
         && wd[BIT_ON];
   endsequence
   sequence s_off_then_out;
      !glb[BIT_ON] ##1 (!dma_on_o && !xfer_allow_o);
   endsequence
   sequence s_on_then_out;
      glb[BIT_ON] ##1 (dma_on_o && module_active_o);
   endsequence

   // ==========================================================
   // enable, suspend and active checks
   chk_on_clear_seq: assert property (s_on_clr_wr |=> s_off_then_out) // RULE4
      else $error("enable clear did not reach outputs");
   chk_on_set_seq: assert property (s_on_set_wr |=> s_on_then_out) // RULE6
      else $error("enable set did not reach outputs");
   chk_susp_set: assert property ( // RULE5
      bus_i.wr && hit(base, OFS_GLOBAL) && kind == ALIAS_SET
         && wd[BIT_SUSPEND]
      |=> ##1 !xfer_allow_o)
      else $error("suspend set did not stop transfers");
   chk_allow_off: assert property ( // RULE4
      !glb[BIT_ON] |=> !xfer_allow_o)
      else $error("transfer allowed while disabled");
   chk_allow_run: assert property ( // RULE5
      glb[BIT_ON] && !glb[BIT_SUSPEND] |=> xfer_allow_o)
      else $error("transfer held off while running");
   chk_active_busy: assert property ( // RULE6
      xfer_busy_i |=> module_active_o)
      else $error("active low during transfer");
   chk_glb_read: assert property ( // RULE6
      bus_i.rd && hit(base, OFS_GLOBAL) && kind == ALIAS_NONE
      |=> rdata_o[BIT_ACTIVE] == $past(busy_q))
      else $error("active bit read wrong");
   chk_glb_unimpl: assert property ( // RULE3
      bus_i.rd && hit(base, OFS_GLOBAL) && kind == ALIAS_NONE
      |=> (rdata_o & ~32'h0000_9800) == 32'h0000_0000)
      else $error("global control unimplemented bit read");

   // ==========================================================
   // alias and read port checks
   chk_alias_rd_zero: assert property ( // RULE3
      bus_i.rd && kind != ALIAS_NONE |=> rdata_o == 32'h0000_0000)
      else $error("alias read not zero");
   chk_rdata_idle: assert property ( // RULE3
      !bus_i.rd |=> rdata_o == 32'h0000_0000)
      else $error("read data without read");
   chk_econ_set: assert property ( // RULE2
      bus_i.wr && hit(base, OFS_C3_ECON) && kind == ALIAS_SET
      |=> c3_econ == (($past(c3_econ) | $past(wd)) & MSK_ECON))
      else $error("extended control set alias wrong");
   chk_ssiz_inv: assert property ( // RULE1
      bus_i.wr && hit(base, OFS_C3_SSIZ) && kind == ALIAS_INV
      |=> c3_ssiz == (($past(c3_ssiz) ^ $past(wd)) & MSK_HALF))
      else $error("source size invert alias wrong");
   chk_dsiz_write: assert property ( // RULE3
      bus_i.wr && hit(base, OFS_C3_DSIZ) && kind == ALIAS_NONE
      |=> c3_dsiz == ($past(wd) & MSK_HALF))
      else $error("destination size write wrong");
   chk_keep_other: assert property ( // RULE2
      bus_i.wr && !hit(base, OFS_C3_SSA) |=> $stable(c3_ssa))
      else $error("source start changed by other write");
   chk_chan_unimpl: assert property ( // RULE3
      (c3_int & ~MSK_INT) == 32'h0 && (c3_con & ~MSK_CON) == 32'h0
         && (c3_dat & ~MSK_BYTE) == 32'h0)
      else $error("channel unimplemented bit set");
   chk_size_unimpl: assert property ( // RULE3
      c3_ssiz[31:16] == 16'h0000 && c3_dsiz[31:16] == 16'h0000
         && c3_csiz[31:16] == 16'h0000)
      else $error("size upper half set");
   chk_ptr_read: assert property ( // RULE3
      bus_i.rd && hit(base, OFS_C3_SPTR) && kind == ALIAS_NONE
      |=> rdata_o == {16'h0000, $past(c3_sptr_i)})
      else $error("source pointer read wrong");

   // ==========================================================
   // interrupt checks
   chk_irq_level: assert property (
      |(irq_stat & irq_mask) |=> irq_o)
      else $error("interrupt low while pending");
   chk_irq_masked: assert property (
      irq_mask == RST_ZERO |=> !irq_o)
      else $error("interrupt high while masked");
   chk_irq_sticky: assert property (
      irq_stat[0] && !(bus_i.wr && hit(base, OFS_IRQ_STAT))
      |=> irq_stat[0])
      else $error("status bit lost without clear");
   chk_irq_event: assert property (
      on_q && !glb[BIT_ON] |=> irq_stat[0])
      else $error("enable clear event not recorded");
endmodule : dgc_regs

// ### testbench/dgc_xfer_model.sv
`timescale 1ns/10ps
module dgc_xfer_model #(
   parameter int LEN = 6
) (
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        allow_i,
   input  wire logic        go_i,
   output logic             busy_o,
   output logic      [15:0] cnt_o
);
   // ==========================================================
   // transfer engine: runs LEN cycles once started, counts cells
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_o <= 1'b0;
         cnt_o  <= 16'h0000;
      end else if (busy_o) begin
         cnt_o  <= cnt_o + 16'h0001;
         busy_o <= (cnt_o != 16'(LEN - 1));
      end else if (go_i && allow_i) begin
         busy_o <= 1'b1;
         cnt_o  <= 16'h0000;
      end
   end
endmodule : dgc_xfer_model

// ### testbench/dgc_regs_tb.sv
`timescale 1ns/10ps
module dgc_regs_tb;
   import dgc_pkg::*;
   localparam int LEN = 6;
   logic        mclk_i, nrst_i, go, busy, allow, on, act, irq;
   dgc_bus_t    bus;
   logic [15:0] cnt;
   logic [31:0] rdata;
   int          n_errors = 0;
   int          comparisons = 0;

   dgc_regs uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .bus_i(bus),
      .xfer_busy_i(busy), .c3_sptr_i(cnt), .c3_dptr_i(cnt),
      .c3_cptr_i(cnt), .c2_cptr_i(~cnt), .rdata_o(rdata),
      .dma_on_o(on), .xfer_allow_o(allow), .module_active_o(act),
      .irq_o(irq));
   dgc_xfer_model #(.LEN(LEN)) xfer (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .allow_i(allow), .go_i(go), .busy_o(busy), .cnt_o(cnt));

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   // ==========================================================
   // bus and check helpers
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h",
                  $time, got, exp);
      end
   endtask : chk
   task wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge mclk_i);
      bus.wr <= 1'b0;
   endtask : wr
   task rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge mclk_i);
      bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd
   task cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : cyc
   task pulse_go;
      @(posedge mclk_i);
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
   endtask : pulse_go
   // ==========================================================
   // scenarios
   task t_reset;
      rd(OFS_C3_ECON, 32'h00FF_FFF8);
      rd(OFS_C3_CON, 32'h0000_0000);
      rd(OFS_C3_DSA, 32'h0000_0000);
      rd(OFS_GLOBAL, 32'h0000_0000);
      chk({31'h0, act}, 32'h0);
   endtask : t_reset
   task t_global;
      wr(OFS_GLOBAL, 32'hFFFF_FFFF);
      cyc(2);
      chk({31'h0, on}, 32'h1);
      chk({31'h0, allow}, 32'h0);
      chk({31'h0, act}, 32'h1);
      rd(OFS_GLOBAL, 32'h0000_9800);
      pulse_go;
      cyc(2);
      chk({31'h0, busy}, 32'h0);
      wr(OFS_GLOBAL + 16'h0004, 32'h0000_1000);
      cyc(2);
      chk({31'h0, allow}, 32'h1);
      rd(OFS_GLOBAL, 32'h0000_8800);
   endtask : t_global
   task t_alias;
      wr(OFS_C3_SSA, 32'hF0F0_F0F0);
      wr(OFS_C3_SSA + 16'h0008, 32'h0000_000F);
      wr(OFS_C3_SSA + 16'h0004, 32'hF000_0000);
      wr(OFS_C3_SSA + 16'h000C, 32'h0000_00FF);
      rd(OFS_C3_SSA, 32'h00F0_F000);
      rd(OFS_C3_SSA + 16'h0004, 32'h0000_0000);
      rd(16'h3360, 32'h0000_0000);
      wr(OFS_C3_DAT, 32'hFFFF_FFFF);
      rd(OFS_C3_DAT, 32'h0000_00FF);
      wr(OFS_C3_ECON + 16'h0004, 32'hFFFF_FFFF);
      rd(OFS_C3_ECON, 32'h0000_0000);
      wr(OFS_C3_ECON + 16'h0008, 32'hFFFF_FFFF);
      rd(OFS_C3_ECON, 32'h00FF_FFF8);
      wr(OFS_C3_CON, 32'hFFFF_FFFF);
      rd(OFS_C3_CON, 32'h0000_81F7);
      wr(OFS_C3_CON, 32'h0000_0000);
      wr(OFS_C3_INT, 32'hFFFF_FFFF);
      rd(OFS_C3_INT, 32'h00FF_00FF);
      wr(OFS_C3_SSIZ, 32'hFFFF_FFFF);
      wr(OFS_C3_SSIZ + 16'h000C, 32'h0000_00FF);
      rd(OFS_C3_SSIZ, 32'h0000_FF00);
      wr(OFS_C3_DSIZ, 32'h1234_5678);
      rd(OFS_C3_DSIZ, 32'h0000_5678);
      wr(OFS_C3_CSIZ, 32'hABCD_0011);
      rd(OFS_C3_CSIZ, 32'h0000_0011);
      wr(OFS_C2_DAT, 32'h0000_1234);
      rd(OFS_C2_DAT, 32'h0000_0034);
   endtask : t_alias
   task t_busy;
      wr(OFS_IRQ_MASK, 32'h0000_0003);
      pulse_go;
      cyc(1);
      wr(OFS_GLOBAL + 16'h0004, 32'h0000_8000);
      cyc(1);
      chk({31'h0, busy}, 32'h1);
      chk({31'h0, act}, 32'h1);
      cyc(LEN);
      chk({31'h0, act}, 32'h0);
      rd(OFS_GLOBAL, 32'h0000_0000);
      wr(OFS_C3_CPTR, 32'hFFFF_FFFF);
      rd(OFS_C3_CPTR, 32'(LEN));
      rd(OFS_C2_CPTR, {16'h0000, ~16'(LEN)});
      rd(OFS_C3_SPTR, 32'(LEN));
      rd(OFS_C3_DPTR, 32'(LEN));
      chk({31'h0, irq}, 32'h1);
      rd(OFS_IRQ_STAT, 32'h0000_0003);
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_STAT, 32'h0000_0003);
      wr(OFS_IRQ_MASK, 32'h0000_0003);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      rd(OFS_IRQ_STAT, 32'h0000_0000);
   endtask : t_busy
   // ==========================================================
   // verdict
   task end_of_test;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   initial begin
      #100000;
      n_errors++;
      end_of_test;
   end
   initial begin
      bus = '0;
      go = 1'b0;
      nrst_i = 1'b0;
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      t_reset;
      t_global;
      t_alias;
      t_busy;
      end_of_test;
   end
endmodule : dgc_regs_tb
